// *** rtl/scg_defs.svh ***
// Offsets, field positions, reset values and timing counts for the sleep clock controller.
`ifndef SCG_DEFS_SVH
`define SCG_DEFS_SVH
`define SCG_OFF_SLEEP_CTRL      12'h000
`define SCG_OFF_GATE_LOW        12'h004
`define SCG_OFF_GATE_HIGH       12'h008
`define SCG_OFF_STATUS          12'h00C
`define SCG_OFF_CONFIG          12'h010
`define SCG_OFF_WAKE_SRC        12'h014
`define SCG_SLEEP_CTRL_RESET    8'h00
`define SCG_GATE_LOW_RESET      8'h00
`define SCG_GATE_HIGH_RESET     8'h00
`define SCG_CONFIG_RESET        8'h00
`define SCG_GATE_LOW_MASK       8'hED
`define SCG_GATE_HIGH_MASK      8'h89
`define SCG_BIT_SLEEP_ENABLE    0
`define SCG_BIT_MODE_LSB        1
`define SCG_BIT_TWO_WIRE        7
`define SCG_BIT_TIMER2          6
`define SCG_BIT_TIMER0          5
`define SCG_BIT_TIMER1          3
`define SCG_BIT_SPI             2
`define SCG_BIT_CONVERTER       0
`define SCG_BIT_USB             7
`define SCG_BIT_TIMER3          3
`define SCG_BIT_SERIAL1         0
`define SCG_BIT_XTAL            0
`define SCG_BIT_T2_ASYNC        1
`define SCG_BIT_CONV_EN         2
`define SCG_BIT_CMP_EN          3
`define SCG_BIT_CMP_VREF        4
`define SCG_BIT_CMP_MUX         5
`define SCG_STANDBY_WAKE_CYCLES 3'd6
`define SCG_RESUME_CYCLES       3'd4
`endif

// *** rtl/scg_pkg.sv ***
// Types shared by the sleep clock controller files.
package scg_pkg;
   typedef enum logic [2:0] {
      SCG_MODE_IDLE     = 3'b000,
      SCG_MODE_NOISE    = 3'b001,
      SCG_MODE_PWR_DOWN = 3'b010,
      SCG_MODE_PWR_SAVE = 3'b011,
      SCG_MODE_RES4     = 3'b100,
      SCG_MODE_RES5     = 3'b101,
      SCG_MODE_STANDBY  = 3'b110,
      SCG_MODE_EXT_STBY = 3'b111
   } scg_mode_type;
   typedef enum logic [3:0] {
      SCG_ST_ACTIVE = 4'b0001,
      SCG_ST_SLEEP  = 4'b0010,
      SCG_ST_WAKE   = 4'b0100,
      SCG_ST_RESUME = 4'b1000
   } scg_state_type;
   typedef struct packed {
      logic core;
      logic flash;
      logic io;
      logic converter;
      logic async_timer;
      logic main_osc;
      logic timer_osc;
   } scg_clocks_type;
   typedef struct packed {
      logic [3:0] pin_low;
      logic [3:0] upper_level;
      logic [3:0] upper_edge;
      logic       pin_change;
      logic       two_wire_match;
      logic       timer2;
      logic       mem_ready;
      logic       converter;
      logic       watchdog;
      logic       other_io;
      logic       usb_sync;
      logic       vbus_transition_irq;
      logic       usb_wakeup_irq;
      logic       id_transition_irq;
      logic       host_wakeup_irq;
   } scg_wake_type;
endpackage

// *** rtl/scg_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module scg_sync #(
   parameter int WIDTH = 1
) (
   input  wire logic             clock_i,
   input  wire logic             reset_i,
   input  wire logic [WIDTH-1:0] data_i,
   output logic      [WIDTH-1:0] data_o
);
   logic [WIDTH-1:0] stage1;
   // The first stage feeds only the second stage to contain metastability.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         stage1 <= '0;
         data_o <= '0;
      end else begin
         stage1 <= data_i;
         data_o <= stage1;
      end
   end
endmodule
`default_nettype wire

// *** rtl/scg_top.sv ***
// Sleep mode sequencer, clock domain enables and peripheral clock gating with an APB slave.
`timescale 1ns/1ps
`default_nettype none
`include "scg_defs.svh"
module scg_top
   import scg_pkg::*;
(
   input  wire logic                 clock_i,
   input  wire logic                 reset_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [11:0]          paddr_i,
   input  wire logic [31:0]          pwdata_i,
   output logic      [31:0]          prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   input  wire logic                 sleep_instr_i,
   input  wire logic                 timer2_enabled_i,
   input  wire logic                 comparator_mux_req_i,
   input  wire scg_wake_type         wake_i,
   output scg_clocks_type            clocks_o,
   output logic      [7:0]           periph_clock_en_o,
   output logic      [7:0]           periph_access_en_o,
   output logic                      sleeping_o,
   output logic                      core_resume_o,
   output logic                      comparator_mux_en_o,
   output logic                      comparator_en_o,
   output logic                      vref_en_o,
   output logic                      converter_en_o,
   output logic                      converter_extended_o
);
   logic [7:0]     sleep_ctrl;
   logic [7:0]     peripheral_clock_gate_low;
   logic [7:0]     peripheral_clock_gate_high;
   logic [7:0]     config_reg;
   scg_mode_type   sleep_mode_select;
   scg_mode_type   active_mode;
   scg_state_type  state;
   scg_state_type  next_state;
   logic [2:0]     count;
   logic [23:0]    wake_sync;
   scg_wake_type   wake_s;
   logic           wake_hit;
   logic           sleep_enable;
   logic           xtal;
   logic           t2_async;
   logic           apb_access;
   logic           addr_ok;
   logic           entry_ok;
   logic           in_idle_or_active;
   logic           converter_prev;
   logic [23:0]    wake_vec;

   assign sleep_enable      = sleep_ctrl[`SCG_BIT_SLEEP_ENABLE];
   assign sleep_mode_select = scg_mode_type'(sleep_ctrl[`SCG_BIT_MODE_LSB +: 3]);
   assign xtal              = config_reg[`SCG_BIT_XTAL];
   assign t2_async          = config_reg[`SCG_BIT_T2_ASYNC];

   // Wake sources come from other clock domains or pins, so each is synchronised.
   assign wake_vec = wake_i;
   scg_sync #(
      .WIDTH (24)
   ) u_wake_sync (
      .clock_i (clock_i),
      .reset_i (reset_i),
      .data_i  (wake_vec),
      .data_o  (wake_sync)
   );
   assign wake_s = scg_wake_type'(wake_sync);

   // A reserved or unsupported mode is refused so the core simply keeps running.
   always_comb begin
      entry_ok = sleep_enable;
      case (sleep_mode_select)
         SCG_MODE_IDLE, SCG_MODE_NOISE, SCG_MODE_PWR_DOWN, SCG_MODE_PWR_SAVE: begin
         end
         SCG_MODE_STANDBY, SCG_MODE_EXT_STBY: begin
            entry_ok = sleep_enable & xtal;
         end
         default: begin
            entry_ok = 1'b0;
         end
      endcase
   end

   // Wake qualification per mode; the async usb group wakes from every mode.
   always_comb begin
      logic deep_pins;
      logic usb_async;
      deep_pins = (|wake_s.pin_low) | (|wake_s.upper_level) | wake_s.pin_change;
      usb_async = wake_s.vbus_transition_irq | wake_s.usb_wakeup_irq
                | wake_s.id_transition_irq | wake_s.host_wakeup_irq;
      case (active_mode)
         SCG_MODE_IDLE: begin
            wake_hit = deep_pins | (|wake_s.upper_edge) | wake_s.two_wire_match
                     | wake_s.timer2 | wake_s.mem_ready | wake_s.converter
                     | wake_s.watchdog | wake_s.other_io | wake_s.usb_sync
                     | usb_async;
         end
         SCG_MODE_NOISE: begin
            wake_hit = deep_pins | wake_s.two_wire_match | (wake_s.timer2 & t2_async)
                     | wake_s.mem_ready | wake_s.converter | wake_s.watchdog
                     | wake_s.usb_sync | usb_async;
         end
         SCG_MODE_PWR_SAVE, SCG_MODE_EXT_STBY: begin
            wake_hit = deep_pins | wake_s.two_wire_match | wake_s.watchdog | usb_async
                     | (wake_s.timer2 & timer2_enabled_i);
         end
         default: begin
            wake_hit = deep_pins | wake_s.two_wire_match | wake_s.watchdog
                     | usb_async;
         end
      endcase
   end

   // Sequencer next state.
   always_comb begin
      next_state = state;
      case (state)
         SCG_ST_ACTIVE: begin
            if (sleep_instr_i && entry_ok) begin
               next_state = SCG_ST_SLEEP;
            end
         end
         SCG_ST_SLEEP: begin
            if (wake_hit) begin
               next_state = SCG_ST_WAKE;
            end
         end
         SCG_ST_WAKE: begin
            if (count == 3'd1) begin
               next_state = SCG_ST_RESUME;
            end
         end
         SCG_ST_RESUME: begin
            next_state = SCG_ST_ACTIVE;
         end
         default: begin
            next_state = SCG_ST_ACTIVE;
         end
      endcase
   end

   // State register and the captured mode for the sleep period.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         state       <= SCG_ST_ACTIVE;
         active_mode <= SCG_MODE_IDLE;
      end else begin
         state <= next_state;
         if (state == SCG_ST_ACTIVE && next_state == SCG_ST_SLEEP) begin
            active_mode <= sleep_mode_select;
         end
      end
   end

   // Wake delay: standby variants restart in six cycles since the oscillator ran.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         count <= 3'd0;
      end else if (state == SCG_ST_SLEEP && wake_hit) begin
         if (active_mode == SCG_MODE_STANDBY || active_mode == SCG_MODE_EXT_STBY) begin
            count <= `SCG_STANDBY_WAKE_CYCLES;
         end else begin
            count <= `SCG_RESUME_CYCLES;
         end
      end else if (state == SCG_ST_WAKE && count != 3'd0) begin
         count <= count - 3'd1;
      end
   end

   // Clock domain enables per mode while asleep.
   always_comb begin
      clocks_o = '{core: 1'b1, flash: 1'b1, io: 1'b1, converter: 1'b1,
                   async_timer: 1'b1, main_osc: 1'b1, timer_osc: t2_async};
      if (state != SCG_ST_ACTIVE) begin
         case (active_mode)
            SCG_MODE_IDLE: begin
               clocks_o.core  = 1'b0;
               clocks_o.flash = 1'b0;
            end
            SCG_MODE_NOISE: begin
               clocks_o.core  = 1'b0;
               clocks_o.flash = 1'b0;
               clocks_o.io    = 1'b0;
            end
            SCG_MODE_PWR_SAVE, SCG_MODE_EXT_STBY: begin
               clocks_o = '{core: 1'b0, flash: 1'b0, io: 1'b0, converter: 1'b0,
                            async_timer: (active_mode == SCG_MODE_PWR_SAVE) | t2_async,
                            main_osc: (active_mode == SCG_MODE_EXT_STBY),
                            timer_osc: t2_async};
            end
            SCG_MODE_STANDBY: begin
               clocks_o = '{core: 1'b0, flash: 1'b0, io: 1'b0, converter: 1'b0,
                            async_timer: 1'b0, main_osc: 1'b1, timer_osc: 1'b0};
            end
            default: begin
               clocks_o = '0;
            end
         endcase
      end
   end

   // Gating bits steer module clocks only in active and idle; the others stop anyway.
   assign in_idle_or_active = (state == SCG_ST_ACTIVE) || (active_mode == SCG_MODE_IDLE);
   always_comb begin
      logic [7:0] gate;
      gate = {peripheral_clock_gate_low[`SCG_BIT_TWO_WIRE],
              peripheral_clock_gate_low[`SCG_BIT_TIMER2] & ~t2_async,
              peripheral_clock_gate_low[`SCG_BIT_TIMER0],
              peripheral_clock_gate_low[`SCG_BIT_TIMER1],
              peripheral_clock_gate_low[`SCG_BIT_SPI],
              peripheral_clock_gate_low[`SCG_BIT_CONVERTER],
              peripheral_clock_gate_high[`SCG_BIT_USB],
              peripheral_clock_gate_high[`SCG_BIT_TIMER3] | peripheral_clock_gate_high[`SCG_BIT_SERIAL1]};
      // Module state is held, not reset, so ungating resumes where it stopped.
      periph_access_en_o = ~gate;
      if (in_idle_or_active) begin
         periph_clock_en_o = ~gate;
      end else begin
         periph_clock_en_o = 8'h00;
      end
      // Timer2 may keep running asynchronously through power-save and extended standby.
      if (!in_idle_or_active && t2_async && timer2_enabled_i) begin
         periph_clock_en_o[6] = 1'b1;
      end
   end

   // Analog side: comparator and converter enables.
   always_comb begin
      logic cmp_on;
      cmp_on = config_reg[`SCG_BIT_CMP_EN];
      if (state != SCG_ST_ACTIVE && active_mode != SCG_MODE_IDLE
          && active_mode != SCG_MODE_NOISE && !config_reg[`SCG_BIT_CMP_VREF]) begin
         cmp_on = 1'b0;
      end
      comparator_en_o     = cmp_on;
      vref_en_o           = cmp_on & config_reg[`SCG_BIT_CMP_VREF];
      comparator_mux_en_o = comparator_mux_req_i
                          & ~peripheral_clock_gate_low[`SCG_BIT_CONVERTER];
      converter_en_o      = config_reg[`SCG_BIT_CONV_EN];
   end

   // An off-to-on converter transition flags the next conversion as extended.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         converter_prev       <= 1'b0;
         converter_extended_o <= 1'b1;
      end else begin
         converter_prev <= converter_en_o;
         if (converter_en_o && !converter_prev) begin
            converter_extended_o <= 1'b1;
         end else if (wake_s.converter) begin
            converter_extended_o <= 1'b0;
         end
      end
   end

   assign sleeping_o    = (state == SCG_ST_SLEEP) || (state == SCG_ST_WAKE);
   assign core_resume_o = (state == SCG_ST_RESUME);

   // APB slave: zero-wait, every access completes in its access cycle.
   assign apb_access = psel_i & penable_i;
   assign pready_o   = 1'b1;
   always_comb begin
      case (paddr_i)
         `SCG_OFF_SLEEP_CTRL, `SCG_OFF_GATE_LOW, `SCG_OFF_GATE_HIGH,
         `SCG_OFF_STATUS, `SCG_OFF_CONFIG, `SCG_OFF_WAKE_SRC: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign pslverr_o = apb_access & ~addr_ok;

   // Register writes; reserved gate bits never store so they read zero.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         sleep_ctrl                 <= `SCG_SLEEP_CTRL_RESET;
         peripheral_clock_gate_low  <= `SCG_GATE_LOW_RESET;
         peripheral_clock_gate_high <= `SCG_GATE_HIGH_RESET;
         config_reg                 <= `SCG_CONFIG_RESET;
      end else if (apb_access && pwrite_i) begin
         case (paddr_i)
            `SCG_OFF_SLEEP_CTRL: sleep_ctrl <= {4'h0, pwdata_i[3:0]};
            `SCG_OFF_GATE_LOW: begin
               peripheral_clock_gate_low <= pwdata_i[7:0] & `SCG_GATE_LOW_MASK;
            end
            `SCG_OFF_GATE_HIGH: begin
               peripheral_clock_gate_high <= pwdata_i[7:0] & `SCG_GATE_HIGH_MASK;
            end
            `SCG_OFF_CONFIG: config_reg <= {2'b00, pwdata_i[5:0]};
            default: begin
            end
         endcase
      end
   end

   // Read data is registered so it is stable during the access phase.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         case (paddr_i)
            `SCG_OFF_SLEEP_CTRL: prdata_o <= {24'h00_0000, sleep_ctrl};
            `SCG_OFF_GATE_LOW:   prdata_o <= {24'h00_0000, peripheral_clock_gate_low};
            `SCG_OFF_GATE_HIGH:  prdata_o <= {24'h00_0000, peripheral_clock_gate_high};
            `SCG_OFF_STATUS:     prdata_o <= {20'h0_0000, 1'b0, active_mode, state, count, 1'b0};
            `SCG_OFF_CONFIG:     prdata_o <= {24'h00_0000, config_reg};
            `SCG_OFF_WAKE_SRC:   prdata_o <= {8'h00, wake_sync};
            default:             prdata_o <= 32'h0000_0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// *** tb/scg_core_model.sv ***
// Behavioural core that issues the sleep instruction and holds interrupt levels until served.
`timescale 1ns/1ps
`default_nettype none
module scg_core_model
   import scg_pkg::*;
(
   input  wire logic         clock_i,
   input  wire logic         reset_i,
   input  wire logic         exec_i,
   input  wire logic         core_resume_i,
   input  wire scg_wake_type wake_req_i,
   output logic              sleep_instr_o,
   output scg_wake_type      wake_o
);
   logic exec_q;
   logic done;
   // One pulse per request; the bench sets sleep enable before it raises the request.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         exec_q        <= 1'b0;
         sleep_instr_o <= 1'b0;
      end else begin
         exec_q        <= exec_i;
         sleep_instr_o <= exec_i && !exec_q;
      end
   end
   // A served interrupt drops at resume, so a held level cannot re-wake a later sleep.
   always_ff @(posedge clock_i) begin
      if (reset_i || wake_req_i == '0) begin
         done <= 1'b0;
      end else if (core_resume_i) begin
         done <= 1'b1;
      end
   end
   assign wake_o = done ? '0 : wake_req_i;
endmodule
`default_nettype wire

// *** tb/scg_top_chk.sv ***
// Concurrent checker for the sleep clock controller, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module scg_top_chk
   import scg_pkg::*;
(
   input wire logic           clock_i,
   input wire logic           reset_i,
   input wire logic           psel_i,
   input wire logic           penable_i,
   input wire logic           pwrite_i,
   input wire logic [11:0]    paddr_i,
   input wire logic [31:0]    pwdata_i,
   input wire logic [31:0]    prdata_o,
   input wire logic           sleep_instr_i,
   input wire scg_clocks_type clocks_o,
   input wire logic [7:0]     periph_clock_en_o,
   input wire logic [7:0]     periph_access_en_o,
   input wire logic           sleeping_o,
   input wire logic           core_resume_o,
   input wire logic           comparator_mux_en_o,
   input wire logic           comparator_en_o,
   input wire logic           converter_en_o
);
   logic [7:0] gl, gh, cfg, ctl;
   logic       wr, rd;
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (reset_i);
   assign wr = psel_i && penable_i && pwrite_i;
   assign rd = psel_i && penable_i && !pwrite_i;
   // Shadow copies of the written registers, taken at the edge where each write completes.
   always_ff @(posedge clock_i) begin
      if (reset_i) begin
         gl  <= 8'h00;
         gh  <= 8'h00;
         cfg <= 8'h00;
         ctl <= 8'h00;
      end else if (wr) begin
         if (paddr_i == 12'h004) gl <= pwdata_i[7:0];
         if (paddr_i == 12'h008) gh <= pwdata_i[7:0];
         if (paddr_i == 12'h010) cfg <= pwdata_i[7:0];
         if (paddr_i == 12'h000) ctl <= pwdata_i[7:0];
      end
   end
   property p_core; $rose(sleeping_o) |-> !clocks_o.core && !clocks_o.flash; endproperty
   a_core: assert property (p_core) else $error("core clock ran in sleep");
   property p_pdown; $rose(sleeping_o) && ctl[3:1] == 3'b010 |-> clocks_o == 7'h00; endproperty
   a_pdown: assert property (p_pdown) else $error("clock ran in power-down");
   property p_entry; $rose(sleeping_o) |-> $past(sleep_instr_i) && ctl[0]; endproperty
   a_entry: assert property (p_entry) else $error("sleep without instruction");
   // Timer2 is left out of the low gate relation because its async select may override it.
   property p_lo; !sleeping_o && !core_resume_o
      |-> periph_clock_en_o[7] == !gl[7] && periph_clock_en_o[3] == !gl[2]; endproperty
   a_lo: assert property (p_lo) else $error("low gate not applied");
   property p_acc; !sleeping_o |-> periph_access_en_o[5] == !gl[5]; endproperty
   a_acc: assert property (p_acc) else $error("gated registers reachable");
   property p_hi; !sleeping_o && !core_resume_o |-> periph_clock_en_o[1] == !gh[7]; endproperty
   a_hi: assert property (p_hi) else $error("high gate not applied");
   property p_rlo; rd && paddr_i == 12'h004 |-> (prdata_o & 32'hFFFF_FF12) == 0; endproperty
   a_rlo: assert property (p_rlo) else $error("low gate reserved bit set");
   property p_rhi; rd && paddr_i == 12'h008 |-> (prdata_o & 32'hFFFF_FF76) == 0; endproperty
   a_rhi: assert property (p_rhi) else $error("high gate reserved bit set");
   property p_res; core_resume_o |-> $past(sleeping_o) ##1 !core_resume_o && !sleeping_o;
   endproperty
   a_res: assert property (p_res) else $error("resume pulse malformed");
   property p_mux; gl[0] |-> !comparator_mux_en_o; endproperty
   a_mux: assert property (p_mux) else $error("mux given while gated");
   property p_cmp; sleeping_o && ctl[2] && !cfg[4] |-> !comparator_en_o; endproperty
   a_cmp: assert property (p_cmp) else $error("comparator on in deep sleep");
   property p_conv; cfg[2] |-> converter_en_o; endproperty
   a_conv: assert property (p_conv) else $error("enabled converter turned off");
endmodule
bind scg_top scg_top_chk chk (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .prdata_o(prdata_o), .sleep_instr_i(sleep_instr_i), .clocks_o(clocks_o),
   .periph_clock_en_o(periph_clock_en_o), .periph_access_en_o(periph_access_en_o),
   .sleeping_o(sleeping_o), .core_resume_o(core_resume_o),
   .comparator_mux_en_o(comparator_mux_en_o), .comparator_en_o(comparator_en_o),
   .converter_en_o(converter_en_o));
`default_nettype wire

// *** tb/scg_top_tb.sv ***
// Self-checking bench for the sleep clock controller.
`timescale 1ns/1ps
`default_nettype none
module scg_top_tb
   import scg_pkg::*;
   ;
   logic           clock_i = 1'b0;
   logic           reset_i = 1'b1;
   logic           psel = 1'b0, penable = 1'b0, pwrite = 1'b0, exec = 1'b0;
   logic [11:0]    paddr = 12'h000;
   logic [31:0]    pwdata = 32'h0000_0000;
   logic           t2_en = 1'b1, mux_req = 1'b1;
   scg_wake_type   wake_req = '0;
   scg_wake_type   wake;
   scg_clocks_type clocks;
   logic [31:0]    prdata, rd;
   logic [7:0]     pce, pae;
   logic           pready, pslverr, sinstr, sleeping, resume, err;
   logic           mux_en, cmp_en, vref_en, conv_en, conv_ext;
   int             fail_count = 0, compares = 0, cycles = 0, lat[6], dmy;
   // Modes in test order and their clock enables while timer2 runs synchronously.
   logic [2:0]     md [6] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd6, 3'd7};
   logic [6:0]     ck [6] = '{7'h1E, 7'h0E, 7'h00, 7'h04, 7'h02, 7'h02};
   always #50 clock_i = ~clock_i;
   scg_top dut (.clock_i(clock_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .sleep_instr_i(sinstr),
      .timer2_enabled_i(t2_en), .comparator_mux_req_i(mux_req), .wake_i(wake),
      .clocks_o(clocks), .periph_clock_en_o(pce), .periph_access_en_o(pae),
      .sleeping_o(sleeping), .core_resume_o(resume), .comparator_mux_en_o(mux_en),
      .comparator_en_o(cmp_en), .vref_en_o(vref_en), .converter_en_o(conv_en),
      .converter_extended_o(conv_ext));
   scg_core_model core (.clock_i(clock_i), .reset_i(reset_i), .exec_i(exec),
      .core_resume_i(resume), .wake_req_i(wake_req), .sleep_instr_o(sinstr), .wake_o(wake));
   task automatic stop_test();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // A hung wait costs one mismatch and ends the run.
   always @(posedge clock_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         stop_test();
      end
   end
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
      compares++;
      if (s !== x) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", n, x, s);
      end
   endtask
   // One APB transfer; the request holds until pready is seen high at a rising edge.
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1'b1;
      @(posedge clock_i);
      while (pready !== 1'b1) begin
         @(posedge clock_i);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic scg_wake_type mk(input int b);
      logic [$bits(scg_wake_type)-1:0] v;
      v = '0;
      v[b] = 1'b1;
      return v;
   endfunction
   // Enters a mode, checks the sleeping enables, then offers wake source b.
   task automatic sleep_try(input logic [2:0] m, input logic se, input logic [7:0] cf,
      input int b, input logic es, input logic ew, input logic [6:0] cx, output int lat);
      apb(1'b1, 12'h010, {24'h0, cf});
      apb(1'b1, 12'h000, {28'h0, m, se});
      exec <= 1'b1;
      lat = 0;
      repeat (4) @(negedge clock_i);
      check("sleeping", sleeping, es);
      if (es) begin
         check("clocks", clocks, cx);
         if (m[1] && !cf[1]) check("gates", pce, 8'h00);
         if (cf[4]) check("vref", vref_en, 1'b1);
         check("cmp", cmp_en, cf[3] & (cf[4] | !m[1]));
         if (cf[2]) check("conv", conv_en, 1'b1);
         @(posedge clock_i);
         wake_req <= mk(b);
         @(negedge clock_i);
         while (resume !== 1'b1 && lat < 40) begin
            @(negedge clock_i);
            lat++;
         end
         check("woken", lat < 40, ew);
         @(posedge clock_i);
         wake_req <= mk(6);
         repeat (40) @(negedge clock_i);
      end
      @(posedge clock_i);
      wake_req <= '0;
      exec <= 1'b0;
      apb(1'b1, 12'h000, 32'h0000_0000);
   endtask
   task automatic t_reset();
      @(negedge clock_i);
      check("reset clocks", clocks, 7'h7E);
      check("reset gates", pce, 8'hFF);
      apb(1'b0, 12'h008, 32'h0000_0000);
      check("high reset", rd, 32'h0000_0000);
   endtask
   task automatic t_regs();
      apb(1'b1, 12'h004, 32'h0000_00FF);
      apb(1'b0, 12'h004, 32'h0000_0000);
      check("low gate", rd, 32'h0000_00ED);
      apb(1'b1, 12'h008, 32'h0000_00FF);
      apb(1'b0, 12'h008, 32'h0000_0000);
      check("high gate", rd, 32'h0000_0089);
      @(negedge clock_i);
      check("all gated", pce, 8'h00);
      check("access", pae, 8'h00);
      apb(1'b1, 12'h010, 32'h0000_0002);
      @(negedge clock_i);
      check("async timer2", pce, 8'h40);
      apb(1'b1, 12'h004, 32'h0000_0000); // Ungated modules resume from their held state.
      apb(1'b1, 12'h008, 32'h0000_0000);
      @(negedge clock_i);
      check("ungated", pce, 8'hFF);
      apb(1'b0, 12'h100, 32'h0000_0000);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0000_0000);
   endtask
   task automatic t_mux();
      apb(1'b1, 12'h010, 32'h0000_0000); // Converter off before its gate is set
      apb(1'b1, 12'h004, 32'h0000_0001);
      @(negedge clock_i);
      check("mux gated", mux_en, 1'b0);
      apb(1'b1, 12'h004, 32'h0000_0000);
      apb(1'b1, 12'h010, 32'h0000_0004);
      @(negedge clock_i);
      check("mux free", mux_en, 1'b1);
      sleep_try(3'd0, 1'b1, 8'h05, 7, 1'b1, 1'b1, 7'h1E, dmy);
      check("ext cleared", conv_ext, 1'b0);
      apb(1'b1, 12'h010, 32'h0000_0001);
      apb(1'b1, 12'h010, 32'h0000_0005);
      repeat (2) @(negedge clock_i);
      check("ext set", conv_ext, 1'b1);
   endtask
   task automatic t_modes();
      for (int i = 0; i < 6; i++) begin
         sleep_try(md[i], 1'b1, 8'h01, 6, 1'b1, 1'b1, ck[i], lat[i]);
      end
      check("standby wake", lat[4], lat[0] + 2);
      check("ext wake", lat[5], lat[0] + 2);
   endtask
   // Wake sources accepted or ignored per mode, with timer2 async where it matters.
   task automatic t_wake();
      sleep_try(3'd2, 1'b1, 8'h01, 5, 1'b1, 1'b0, 7'h00, dmy);
      sleep_try(3'd2, 1'b1, 8'h01, 12, 1'b1, 1'b0, 7'h00, dmy);
      sleep_try(3'd2, 1'b1, 8'h01, 16, 1'b1, 1'b1, 7'h00, dmy);
      sleep_try(3'd3, 1'b1, 8'h03, 9, 1'b1, 1'b1, 7'h05, dmy);
      sleep_try(3'd7, 1'b1, 8'h03, 9, 1'b1, 1'b1, 7'h07, dmy);
      sleep_try(3'd6, 1'b1, 8'h01, 9, 1'b1, 1'b0, 7'h02, dmy);
      sleep_try(3'd0, 1'b1, 8'h01, 5, 1'b1, 1'b1, 7'h1E, dmy);
      sleep_try(3'd1, 1'b1, 8'h01, 5, 1'b1, 1'b0, 7'h0E, dmy);
      sleep_try(3'd1, 1'b1, 8'h01, 3, 1'b1, 1'b1, 7'h0E, dmy);
      sleep_try(3'd2, 1'b1, 8'h01, 0, 1'b1, 1'b1, 7'h00, dmy);
      sleep_try(3'd2, 1'b1, 8'h0D, 6, 1'b1, 1'b1, 7'h00, dmy);
      sleep_try(3'd2, 1'b1, 8'h1D, 6, 1'b1, 1'b1, 7'h00, dmy);
   endtask
   task automatic t_refuse();
      sleep_try(3'd4, 1'b1, 8'h01, 6, 1'b0, 1'b0, 7'h00, dmy);
      sleep_try(3'd5, 1'b1, 8'h01, 6, 1'b0, 1'b0, 7'h00, dmy);
      sleep_try(3'd0, 1'b0, 8'h01, 6, 1'b0, 1'b0, 7'h00, dmy);
      sleep_try(3'd6, 1'b1, 8'h00, 6, 1'b0, 1'b0, 7'h00, dmy);
      sleep_try(3'd7, 1'b1, 8'h00, 6, 1'b0, 1'b0, 7'h00, dmy);
   endtask
   initial begin
      repeat (5) @(posedge clock_i);
      reset_i <= 1'b0;
      t_reset();
      t_regs();
      t_mux();
      t_modes();
      t_wake();
      t_refuse();
      stop_test();
   end
endmodule
`default_nettype wire
